// [design/iod_pkg.sv]
// constants, types and register map of the lower i/o register decode
// How it works
// RL1: software writes zero into reserved bits
// RL2: reserved bits read back unspecified, here zero
// RL3: software never writes reserved i/o addresses
// RL4: low 32 locations allow single-bit set/clear
// RL5: low 32 locations allow bit test skip
// RL6: flag cleared by writing one, zero ignored
// RL7: bit set/clear rewrite whole register, clearing flags
// RL8: data space reaches i/o at plus 0x20
// RL9: extended region only through data space ops
package iod_pkg;
   // ==========================================================
   // register offsets in i/o space
   localparam logic [5:0] IOD_PORT_B_PIN_INPUT = 6'h03;
   localparam logic [5:0] IOD_PORT_B_DIRECTION = 6'h04;
   localparam logic [5:0] IOD_PORT_B_OUTPUT = 6'h05;
   localparam logic [5:0] IOD_PORT_C_PIN_INPUT = 6'h06;
   localparam logic [5:0] IOD_PORT_C_DIRECTION = 6'h07;
   localparam logic [5:0] IOD_PORT_C_OUTPUT = 6'h08;
   localparam logic [5:0] IOD_PORT_D_PIN_INPUT = 6'h09;
   localparam logic [5:0] IOD_PORT_D_DIRECTION = 6'h0a;
   localparam logic [5:0] IOD_PORT_D_OUTPUT = 6'h0b;
   localparam logic [5:0] IOD_TIMER8_FLAGS = 6'h15;
   localparam logic [5:0] IOD_TIMER16_FLAGS = 6'h16;
   localparam logic [5:0] IOD_EXT_INT_MASK = 6'h1d;
   localparam logic [5:0] IOD_GENERAL_SCRATCH_ZERO = 6'h1e;
   localparam logic [5:0] IOD_EEPROM_CONTROL = 6'h1f;
   localparam logic [5:0] IOD_EEPROM_DATA = 6'h20;
   localparam logic [5:0] IOD_EEPROM_ADDR_LOW = 6'h21;
   localparam logic [5:0] IOD_EEPROM_ADDR_HIGH = 6'h22;
   localparam logic [5:0] IOD_TIMER_GLOBAL_CONTROL = 6'h23;
   localparam logic [5:0] IOD_TIMER8_CONTROL_A = 6'h24;
   localparam logic [5:0] IOD_TIMER8_CONTROL_B = 6'h25;
   localparam logic [5:0] IOD_TIMER8_COUNT = 6'h26;
   localparam logic [5:0] IOD_TIMER8_COMPARE_A = 6'h27;
   localparam logic [5:0] IOD_TIMER8_COMPARE_B = 6'h28;
   localparam logic [5:0] IOD_LAST_REG = 6'h28;
   localparam int IOD_NUM_REGS = 41;
   // ==========================================================
   // address windows
   localparam logic [5:0] IOD_BIT_OP_LIMIT = 6'h1f;
   localparam logic [8:0] IOD_DATA_IO_OFFSET = 9'h020;
   localparam logic [8:0] IOD_EXT_BASE = 9'h060;
   // ==========================================================
   // implemented bits per register and reset value
   localparam logic [7:0] IOD_FULL_MASK = 8'hff;
   localparam logic [7:0] IOD_PORT_C_MASK = 8'hf7;
   localparam logic [7:0] IOD_TIMER8_FLAGS_MASK = 8'h07;
   localparam logic [7:0] IOD_TIMER16_FLAGS_MASK = 8'h2f;
   localparam logic [7:0] IOD_EEPROM_CONTROL_MASK = 8'h3f;
   localparam logic [7:0] IOD_GLOBAL_CONTROL_MASK = 8'h83;
   localparam logic [7:0] IOD_TIMER8_CONTROL_A_MASK = 8'hf3;
   localparam logic [7:0] IOD_TIMER8_CONTROL_B_MASK = 8'hcf;
   localparam logic [7:0] IOD_REG_RESET = 8'h00;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      IOD_IO_IN_OP = 3'h0,
      IOD_IO_OUT_OP = 3'h1,
      IOD_DATA_LOAD_OP = 3'h2,
      IOD_DATA_STORE_OP = 3'h3,
      IOD_SINGLE_BIT_SET_OP = 3'h4,
      IOD_SINGLE_BIT_CLEAR_OP = 3'h5,
      IOD_SKIP_IF_IO_BIT_SET_OP = 3'h6,
      IOD_SKIP_IF_IO_BIT_CLEAR_OP = 3'h7
   } iod_op_t;
   typedef struct packed {
      logic valid;
      iod_op_t op;
      logic [8:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } iod_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic skip;
      logic refused;
      logic ext;
   } iod_resp_t;
   typedef struct packed {
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
   } iod_pins_t;
   typedef logic [IOD_NUM_REGS-1:0][7:0] iod_regs_t;
   typedef struct packed {
      iod_regs_t regs;
      iod_pins_t sync1;
      iod_pins_t sync2;
      iod_resp_t resp;
   } iod_state_t;
   // ==========================================================
   // writable bits of each i/o location; zero means not writable
   function automatic logic [7:0] iod_wmask(input logic [5:0] a);
      case (a)
         IOD_PORT_B_DIRECTION, IOD_PORT_B_OUTPUT,
         IOD_PORT_D_DIRECTION, IOD_PORT_D_OUTPUT,
         IOD_EXT_INT_MASK, IOD_GENERAL_SCRATCH_ZERO,
         IOD_EEPROM_DATA, IOD_EEPROM_ADDR_LOW,
         IOD_EEPROM_ADDR_HIGH, IOD_TIMER8_COUNT,
         IOD_TIMER8_COMPARE_A,
         IOD_TIMER8_COMPARE_B: return IOD_FULL_MASK;
         IOD_PORT_C_DIRECTION,
         IOD_PORT_C_OUTPUT: return IOD_PORT_C_MASK;
         IOD_TIMER8_FLAGS: return IOD_TIMER8_FLAGS_MASK;
         IOD_TIMER16_FLAGS: return IOD_TIMER16_FLAGS_MASK;
         IOD_EEPROM_CONTROL: return IOD_EEPROM_CONTROL_MASK;
         IOD_TIMER_GLOBAL_CONTROL: return IOD_GLOBAL_CONTROL_MASK;
         IOD_TIMER8_CONTROL_A: return IOD_TIMER8_CONTROL_A_MASK;
         IOD_TIMER8_CONTROL_B: return IOD_TIMER8_CONTROL_B_MASK;
         default: return 8'h00;
      endcase
   endfunction
endpackage

// [design/iod_decode.sv]
// lower i/o register space decode and register bank as seen by the core
`timescale 1ns/1ps
`default_nettype none
module iod_decode
   import iod_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire iod_req_t i_req,
   input wire iod_pins_t i_pins,
   input wire logic [7:0] i_timer8_events,
   input wire logic [7:0] i_timer16_events,
   output iod_resp_t o_resp,
   output iod_regs_t o_regs
);
   // ==========================================================
   // state and decode variables
   iod_state_t st_q;
   iod_state_t st_d;
   logic [5:0] io_a;
   logic io_hit;
   logic is_wr;
   logic is_rd;
   logic ext;
   logic refused;
   logic skip;
   logic [7:0] wval;
   logic [7:0] rd;
   logic [7:0] bm;
   logic [7:0] wm;
   logic w1c;

   // ==========================================================
   // next state
   always_comb
   begin
      st_d = st_q;
      // first stage only feeds the second
      st_d.sync1 = i_pins;
      st_d.sync2 = st_q.sync1;
      st_d.resp = '0;
      io_a = i_req.addr[5:0];
      io_hit = 1'b0;
      is_wr = 1'b0;
      is_rd = 1'b0;
      ext = 1'b0;
      refused = 1'b0;
      skip = 1'b0;
      wval = i_req.wdata;
      bm = 8'h01 << i_req.bit_sel;
      case (i_req.op)
         IOD_IO_IN_OP:
         begin
            io_hit = 1'b1; // [RL8]
            is_rd = 1'b1;
         end
         IOD_IO_OUT_OP:
         begin
            io_hit = 1'b1; // [RL8]
            is_wr = 1'b1;
         end
         IOD_DATA_LOAD_OP, IOD_DATA_STORE_OP:
         begin
            // extended region has its own decoder elsewhere
            if (i_req.addr >= IOD_EXT_BASE)
               ext = 1'b1; // [RL9]
            else if (i_req.addr >= IOD_DATA_IO_OFFSET)
            begin
               io_hit = 1'b1;
               io_a = 6'(i_req.addr - IOD_DATA_IO_OFFSET); // [RL8]
               is_wr = (i_req.op == IOD_DATA_STORE_OP);
               is_rd = ~is_wr;
            end
            else
               refused = 1'b1;
         end
         default:
         begin
            // bit ops only reach the low 32 locations
            if (i_req.addr > 9'(IOD_BIT_OP_LIMIT))
               refused = 1'b1; // [RL4]
            else
               io_hit = 1'b1;
         end
      endcase
      // read path; reserved bits are never stored so read zero
      case (io_a)
         IOD_PORT_B_PIN_INPUT: rd = st_q.sync2.b;
         IOD_PORT_C_PIN_INPUT: rd = st_q.sync2.c & IOD_PORT_C_MASK;
         IOD_PORT_D_PIN_INPUT: rd = st_q.sync2.d;
         default: rd = (io_a <= IOD_LAST_REG) ? st_q.regs[io_a] : 8'h00;
      endcase // [RL2]
      if (io_hit)
      begin
         case (i_req.op)
            IOD_SINGLE_BIT_SET_OP:
            begin
               is_wr = 1'b1;
               wval = rd | bm; // [RL4] [RL7]
            end
            IOD_SINGLE_BIT_CLEAR_OP:
            begin
               is_wr = 1'b1;
               wval = rd & ~bm; // [RL4] [RL7]
            end
            IOD_SKIP_IF_IO_BIT_SET_OP: skip = rd[i_req.bit_sel]; // [RL5]
            IOD_SKIP_IF_IO_BIT_CLEAR_OP: skip = ~rd[i_req.bit_sel]; // [RL5]
            default: skip = 1'b0;
         endcase
      end
      // write path; reserved and pin locations ignore writes
      wm = iod_wmask(io_a);
      w1c = (io_a == IOD_TIMER8_FLAGS) || (io_a == IOD_TIMER16_FLAGS);
      if (i_req.valid && io_hit && is_wr && io_a <= IOD_LAST_REG)
      begin
         if (w1c)
            st_d.regs[io_a] = st_q.regs[io_a] & ~(wval & wm); // [RL6]
         else if (wm != 8'h00)
            st_d.regs[io_a] = wval & wm;
      end
      // a flag event in the clearing cycle wins over the clear
      st_d.regs[IOD_TIMER8_FLAGS] = st_d.regs[IOD_TIMER8_FLAGS]
         | (i_timer8_events & IOD_TIMER8_FLAGS_MASK);
      st_d.regs[IOD_TIMER16_FLAGS] = st_d.regs[IOD_TIMER16_FLAGS]
         | (i_timer16_events & IOD_TIMER16_FLAGS_MASK);
      st_d.resp.valid = i_req.valid;
      st_d.resp.rdata = (i_req.valid && io_hit && is_rd) ? rd : 8'h00;
      st_d.resp.skip = i_req.valid & skip;
      st_d.resp.refused = i_req.valid & refused;
      st_d.resp.ext = i_req.valid & ext;
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign o_resp = st_q.resp;
   assign o_regs = st_q.regs;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   logic quiet8;
   logic [7:0] skip_ref;
   assign quiet8 = (i_timer8_events & IOD_TIMER8_FLAGS_MASK) == 8'h00;
   assign skip_ref = (i_req.addr[5:0] <= IOD_LAST_REG)
      ? o_regs[i_req.addr[5:0]] : 8'h00;

   sequence flags_out_s(logic [7:0] v);
      i_req.valid && i_req.op == IOD_IO_OUT_OP
         && i_req.addr[5:0] == IOD_TIMER8_FLAGS && i_req.wdata == v
         && quiet8;
   endsequence

   sequence bit_set_flags_s;
      i_req.valid && i_req.op == IOD_SINGLE_BIT_SET_OP
         && i_req.addr == 9'(IOD_TIMER8_FLAGS) && quiet8;
   endsequence

   bit_range_a: assert property ( // [RL4]
      i_req.valid && i_req.op >= IOD_SINGLE_BIT_SET_OP
         && i_req.addr > 9'(IOD_BIT_OP_LIMIT)
      |=> o_resp.refused && !o_resp.skip)
      else $error("bit op above low range not refused");

   skip_set_a: assert property ( // [RL5]
      i_req.valid && i_req.op == IOD_SKIP_IF_IO_BIT_SET_OP
         && i_req.addr == 9'(IOD_GENERAL_SCRATCH_ZERO)
      |=> o_resp.skip == $past(skip_ref[i_req.bit_sel]))
      else $error("skip if set wrong");

   skip_clear_a: assert property ( // [RL5]
      i_req.valid && i_req.op == IOD_SKIP_IF_IO_BIT_CLEAR_OP
         && i_req.addr == 9'(IOD_EXT_INT_MASK)
         && o_regs[IOD_EXT_INT_MASK] == 8'h00
      |=> o_resp.skip)
      else $error("skip if clear missed a clear bit");

   w1c_zero_a: assert property ( // [RL6]
      flags_out_s(8'h00) |=> $stable(o_regs[IOD_TIMER8_FLAGS]))
      else $error("writing zero changed a flag");

   w1c_one_a: assert property ( // [RL6]
      flags_out_s(8'hff) |=> o_regs[IOD_TIMER8_FLAGS] == 8'h00)
      else $error("writing one did not clear flags");

   rmw_clear_a: assert property ( // [RL7]
      bit_set_flags_s |=> o_regs[IOD_TIMER8_FLAGS] == 8'h00 && o_resp.valid)
      else $error("bit set left a set flag standing");

   mirror_a: assert property ( // [RL8]
      i_req.valid && i_req.op == IOD_DATA_STORE_OP
         && i_req.addr == IOD_DATA_IO_OFFSET + 9'(IOD_PORT_B_OUTPUT)
      |=> o_regs[IOD_PORT_B_OUTPUT] == $past(i_req.wdata))
      else $error("data space store missed mirrored register");

   ext_only_a: assert property ( // [RL9]
      i_req.valid && i_req.op == IOD_DATA_STORE_OP
         && i_req.addr >= IOD_EXT_BASE
      |=> o_resp.ext && $stable(o_regs))
      else $error("extended store touched i/o bank");

   rsv_read_a: assert property ( // [RL2]
      i_req.valid && i_req.op == IOD_IO_IN_OP
         && i_req.addr[5:0] == IOD_PORT_C_OUTPUT
      |=> o_resp.rdata[3] == 1'b0 && o_resp.valid)
      else $error("reserved bit read nonzero");
endmodule // iod_decode
`default_nettype wire

// [sim/iod_core_model.sv]
// core model issuing i/o and data-space requests to the decode
`timescale 1ns/1ps
`default_nettype none
module iod_core_model
   import iod_pkg::*;
(
   input wire logic i_clock,
   input wire iod_resp_t i_resp,
   output iod_req_t o_req
);
   // ==========================================================
   // one request per call: raised and released on falling edges
   initial o_req = '0;
   task automatic access(input iod_op_t op, input logic [8:0] a,
      input logic [2:0] b, input logic [7:0] wd, output iod_resp_t r);
      @(negedge i_clock);
      o_req = '{1'b1, op, a, b, wd};
      @(posedge i_clock);
      #1;
      r = i_resp;
      @(negedge i_clock);
      // released data must not keep showing the last byte
      o_req = '{1'b0, op, a, b, ~wd};
   endtask
endmodule // iod_core_model
`default_nettype wire

// [sim/tb.sv]
// self-checking testbench of the lower i/o register decode
`timescale 1ns/1ps
`default_nettype none
module tb;
   import iod_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   iod_req_t req;
   iod_pins_t i_pins = '0;
   logic [7:0] i_timer8_events = 8'h00;
   logic [7:0] i_timer16_events = 8'h00;
   iod_resp_t o_resp, r;
   iod_regs_t o_regs;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   integer seed = 32'h03bf;
   logic [7:0] v, s;
   logic [7:0] ex [64];
   // writable map only; reserved places are never written
   logic [5:0] rw [18] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0a, 6'h0b,
      6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25,
      6'h26, 6'h27, 6'h28};
   logic [8:0] xa [4] = '{9'h060, 9'h1ff, 9'h05f, 9'h048};
   always #12.5 i_clock = ~i_clock;
   iod_decode dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req),
      .i_pins(i_pins), .i_timer8_events(i_timer8_events),
      .i_timer16_events(i_timer16_events), .o_resp(o_resp),
      .o_regs(o_regs));
   iod_core_model core_u (.i_clock(i_clock), .i_resp(o_resp),
      .o_req(req));
   // ==========================================================
   // expectations and checks
   function automatic logic [7:0] m(input logic [5:0] a);
      case (a)
         6'h07, 6'h08: return 8'hf7;
         6'h1f: return 8'h3f;
         6'h23: return 8'h83;
         6'h24: return 8'hf3;
         6'h25: return 8'hcf;
         default: return 8'hff;
      endcase
   endfunction
   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic op(input iod_op_t o, input logic [8:0] a,
      input logic [2:0] b, input logic [7:0] wd);
      core_u.access(o, a, b, wd, r);
      chk("resp valid", 8'h01, {7'h0, r.valid});
      // the answer stands one cycle; look once the idle edge has passed
      @(negedge i_clock);
      chk("valid drop", 8'h00, {7'h0, o_resp.valid});
   endtask
   task automatic end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard, far above the four hundred or so cycles the tests need
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         end_sim();
      end
   end
   // ==========================================================
   // main sequence
   initial
   begin
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      i_rst_n = 1'b1;
      for (int a = 0; a < 41; a++) chk("reset", 8'h00, o_regs[a]);
      $display("test reset done");
      foreach (rw[k])
      begin
         v = 8'($random(seed)) & m(rw[k]);
         op(IOD_IO_OUT_OP, {3'h0, rw[k]}, 3'h0, v);
         chk("image", v, o_regs[rw[k]]);
         op(IOD_IO_IN_OP, {3'h0, rw[k]}, 3'h0, 8'h00);
         chk("in", v, r.rdata);
         op(IOD_DATA_LOAD_OP, {3'h0, rw[k]} + 9'h020, 3'h0, 8'h00);
         chk("load", v, r.rdata);
         ex[rw[k]] = ~v & m(rw[k]);
         op(IOD_DATA_STORE_OP, {3'h0, rw[k]} + 9'h020, 3'h0, ex[rw[k]]);
         chk("store", ex[rw[k]], o_regs[rw[k]]);
      end
      $display("test dual addressing done");
      s = 8'h5a;
      op(IOD_IO_OUT_OP, 9'h01e, 3'h0, s);
      for (int b = 0; b < 8; b++)
      begin
         s[b] = 1'b1;
         op(IOD_SINGLE_BIT_SET_OP, 9'h01e, 3'(b), 8'h00);
         chk("bit set", s, o_regs[6'h1e]);
         op(IOD_SKIP_IF_IO_BIT_SET_OP, 9'h01e, 3'(b), 8'h00);
         chk("skip set", 8'h01, {7'h0, r.skip});
         s[7-b] = 1'b0;
         op(IOD_SINGLE_BIT_CLEAR_OP, 9'h01e, 3'(7-b), 8'h00);
         chk("bit clear", s, o_regs[6'h1e]);
         op(IOD_SKIP_IF_IO_BIT_CLEAR_OP, 9'h01e, 3'(7-b), 8'h00);
         chk("skip clear", 8'h01, {7'h0, r.skip});
         op(IOD_SKIP_IF_IO_BIT_SET_OP, 9'h01e, 3'(7-b), 8'h00);
         chk("no skip", 8'h00, {7'h0, r.skip});
      end
      op(IOD_IO_OUT_OP, 9'h01d, 3'h0, 8'h00);
      op(IOD_SKIP_IF_IO_BIT_CLEAR_OP, 9'h01d, 3'($random(seed)), 8'h00);
      chk("skip clear zero", 8'h01, {7'h0, r.skip});
      op(IOD_SINGLE_BIT_SET_OP, 9'h020, 3'h0, 8'h00);
      chk("refused", 8'h01, {7'h0, r.refused});
      chk("no write", ex[6'h20], o_regs[6'h20]);
      $display("test bit access done");
      @(negedge i_clock);
      i_timer8_events = 8'hff;
      i_timer16_events = 8'hff;
      @(negedge i_clock);
      i_timer8_events = 8'h00;
      i_timer16_events = 8'h00;
      chk("flags8", 8'h07, o_regs[6'h15]);
      chk("flags16", 8'h2f, o_regs[6'h16]);
      op(IOD_IO_OUT_OP, 9'h015, 3'h0, 8'h02);
      chk("one clears", 8'h05, o_regs[6'h15]);
      op(IOD_IO_OUT_OP, 9'h015, 3'h0, 8'h00);
      chk("zero keeps", 8'h05, o_regs[6'h15]);
      op(IOD_SINGLE_BIT_CLEAR_OP, 9'h015, 3'h1, 8'h00);
      chk("clear rmw", 8'h00, o_regs[6'h15]);
      op(IOD_SINGLE_BIT_SET_OP, 9'h016, 3'h1, 8'h00);
      chk("set rmw", 8'h00, o_regs[6'h16]);
      @(negedge i_clock);
      i_timer8_events = 8'hff;
      @(negedge i_clock);
      i_timer8_events = 8'h00;
      op(IOD_IO_OUT_OP, 9'h015, 3'h0, 8'hff);
      chk("ones clear", 8'h00, o_regs[6'h15]);
      @(negedge i_clock);
      i_timer8_events = 8'hff;
      @(negedge i_clock);
      i_timer8_events = 8'h00;
      op(IOD_SINGLE_BIT_SET_OP, 9'h015, 3'h2, 8'h00);
      chk("set rmw8", 8'h00, o_regs[6'h15]);
      $display("test flags done");
      foreach (xa[k])
      begin
         op(IOD_DATA_LOAD_OP, xa[k], 3'h0, 8'h00);
         chk("ext", {7'h0, k < 2}, {7'h0, r.ext});
         if (k < 2)
         begin
            op(IOD_DATA_STORE_OP, xa[k], 3'h0, 8'(k + 1));
            chk("ext store", 8'h01, {7'h0, r.ext});
            chk("ext no write", ex[6'h20], o_regs[6'h20]);
         end
      end
      op(IOD_DATA_LOAD_OP, 9'h01f, 3'h0, 8'h00);
      chk("low load", 8'h01, {7'h0, r.refused});
      @(negedge i_clock);
      i_pins = 24'($random(seed));
      repeat (3) @(negedge i_clock);
      op(IOD_IO_IN_OP, 9'h003, 3'h0, 8'h00);
      chk("pin b", i_pins.b, r.rdata);
      op(IOD_IO_IN_OP, 9'h006, 3'h0, 8'h00);
      chk("pin c", i_pins.c & 8'hf7, r.rdata);
      op(IOD_DATA_LOAD_OP, 9'h029, 3'h0, 8'h00);
      chk("pin d", i_pins.d, r.rdata);
      $display("test extended and pins done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
